// [common/io_expander_pkg.sv]
// shared constants and types for the 16-bit serial-bus port expander
package io_expander_pkg;
    localparam logic [2:0] REG_PIN_LEVEL_LO   = 3'h0;
    localparam logic [2:0] REG_PIN_LEVEL_HI   = 3'h1;
    localparam logic [2:0] REG_DRIVE_VALUE_LO = 3'h2;
    localparam logic [2:0] REG_DRIVE_VALUE_HI = 3'h3;
    localparam logic [2:0] REG_INVERT_MASK_LO = 3'h4;
    localparam logic [2:0] REG_INVERT_MASK_HI = 3'h5;
    localparam logic [2:0] REG_DIRECTION_LO   = 3'h6;
    localparam logic [2:0] REG_DIRECTION_HI   = 3'h7;

    localparam logic [7:0] DRIVE_VALUE_RESET  = 8'hFF;
    localparam logic [7:0] INVERT_MASK_RESET  = 8'h00;
    localparam logic [7:0] DIRECTION_RESET    = 8'hFF;
    localparam logic [7:0] COMMAND_RESET      = 8'h00;

    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
    localparam int         SYNC_WIDTH         = 21;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } port_pair_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_MACK
    } link_state_t;
endpackage : io_expander_pkg

// [logic/sync_two_stage.sv]
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module sync_two_stage #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1)
    begin : g_width_check
        $error("sync_two_stage: WIDTH must be at least 1");
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            meta   <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else if (i_ce)
        begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule : sync_two_stage

// [logic/port_sense.sv]
// polarity adjust and change detection for both 8-bit ports
`timescale 1ns/1ns
module port_sense (
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset,
    input  wire io_expander_pkg::port_pair_t i_pin_sync,
    input  wire io_expander_pkg::port_pair_t i_invert,
    input  wire io_expander_pkg::port_pair_t i_direction,
    input  wire io_expander_pkg::port_pair_t i_snapshot,
    output io_expander_pkg::port_pair_t   o_level,
    output io_expander_pkg::port_pair_t   o_mismatch
);
    // level after the invert mask is what the input registers report
    assign o_level    = i_pin_sync ^ i_invert;
    // only input pins are compared with the last value read
    assign o_mismatch = (o_level ^ i_snapshot) & i_direction;

    a_output_masked: assert property (@(posedge i_mclk) disable iff (i_reset)
        (o_mismatch & ~i_direction) == 16'h0000)
        else $error("output pin reported a change");
endmodule : port_sense

// [logic/io_expander_core.sv]
// serial-bus slave with eight paired registers and two 8-bit ports
`timescale 1ns/1ns
// How it works
// - slave address holds three strap inputs, giving eight distinct addresses
// - address byte bit 0: one reads from device, zero writes to it
// - first byte after write address is the command, kept write-only
// - only the low three command bits select among eight registers
// - codes 0-1 levels, 2-3 drive, 4-5 invert, 6-7 direction
// - level registers show pin state in any direction; writes ignored
// - drive bits matter only on output pins
// - drive register reads return the written value, not the pin
// - both drive registers reset to all ones
// - invert bit one reports the pin level inverted
// - both invert registers reset to zero
// - direction one means input, zero means driven output
// - both direction registers reset to ones, all pins inputs
// - outputs drive the stored value; inputs have both drivers off
// - reset puts every register and the bus machine in default state
// - any edge on an input pin raises the interrupt
// - interrupt drops when the pin returns or its port is read
// - read clear happens at the acknowledge bit after the clock rises
// - changes during the acknowledge pulse may be lost; later ones re-raise
// - output pins never cause an interrupt
// - turning an output into an input may raise a false interrupt
// - interrupt output is open-drain, low while pending
// - multi-byte writes alternate between the two registers of a pair
// - multi-byte reads alternate; pointer keeps toggled value over restart
module io_expander_core #(
    parameter logic [3:0] ADDR_BASE = 4'h2
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset,
    input  wire logic                        i_ce,
    input  wire logic                        i_scl,
    input  wire logic                        i_sda,
    output logic                             o_sda,
    output logic                             o_sda_oe_n,
    input  wire logic [2:0]                  i_addr_strap,
    input  wire io_expander_pkg::port_pair_t i_port_pin,
    output io_expander_pkg::port_pair_t      o_port_pin,
    output io_expander_pkg::port_pair_t      o_port_oe_n,
    output logic                             o_int,
    output logic                             o_int_oe_n
);
    localparam int SW = io_expander_pkg::SYNC_WIDTH;

    logic [SW-1:0]                sync_out;
    logic [2:0]                   strap;
    logic                         scl_s;
    logic                         sda_s;
    io_expander_pkg::port_pair_t  pin_s;
    logic                         scl_q;
    logic                         sda_q;
    io_expander_pkg::link_state_t state;
    logic [3:0]                   bit_cnt;
    logic [7:0]                   shift;
    logic                         rw;
    logic                         acked;
    logic [7:0]                   ptr;
    io_expander_pkg::port_pair_t  drive;
    io_expander_pkg::port_pair_t  invert;
    io_expander_pkg::port_pair_t  direction;
    io_expander_pkg::port_pair_t  snapshot;
    io_expander_pkg::port_pair_t  level;
    io_expander_pkg::port_pair_t  mismatch;
    logic                         primed;
    logic [1:0]                   warm;
    logic                         next_sda_oe_n;

    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
        shift_in = {cur[6:0], bit_in};
    endfunction : shift_in

    function automatic logic [7:0] read_value(input logic [2:0] sel,
                                              input io_expander_pkg::port_pair_t lvl,
                                              input io_expander_pkg::port_pair_t drv,
                                              input io_expander_pkg::port_pair_t inv,
                                              input io_expander_pkg::port_pair_t dir);
        unique case (sel)
            io_expander_pkg::REG_PIN_LEVEL_LO:   read_value = lvl.lo;
            io_expander_pkg::REG_PIN_LEVEL_HI:   read_value = lvl.hi;
            io_expander_pkg::REG_DRIVE_VALUE_LO: read_value = drv.lo;
            io_expander_pkg::REG_DRIVE_VALUE_HI: read_value = drv.hi;
            io_expander_pkg::REG_INVERT_MASK_LO: read_value = inv.lo;
            io_expander_pkg::REG_INVERT_MASK_HI: read_value = inv.hi;
            io_expander_pkg::REG_DIRECTION_LO:   read_value = dir.lo;
            io_expander_pkg::REG_DIRECTION_HI:   read_value = dir.hi;
        endcase
    endfunction : read_value

    // straps, bus lines and port pins all come from outside the clock domain
    sync_two_stage #(
        .WIDTH     (SW),
        .RESET_VAL ({SW{1'b1}})
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async ({i_addr_strap, i_scl, i_sda, i_port_pin}),
        .o_sync  (sync_out)
    );

    assign strap = sync_out[20:18];
    assign scl_s = sync_out[17];
    assign sda_s = sync_out[16];
    assign pin_s = sync_out[15:0];

    port_sense u_sense (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_pin_sync  (pin_s),
        .i_invert    (invert),
        .i_direction (direction),
        .i_snapshot  (snapshot),
        .o_level     (level),
        .o_mismatch  (mismatch)
    );

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else if (i_ce)
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
    wire byte_end  = scl_fall && (bit_cnt == io_expander_pkg::BITS_PER_BYTE);
    wire addr_hit  = (state == io_expander_pkg::ST_ADDR) && byte_end
                     && (shift[7:1] == {ADDR_BASE, strap});
    wire cmd_done  = (state == io_expander_pkg::ST_CMD) && byte_end;
    wire wr_done   = (state == io_expander_pkg::ST_WDATA) && byte_end;
    wire mack_rise = (state == io_expander_pkg::ST_MACK) && scl_rise;
    wire [7:0] rd_byte = read_value(ptr[2:0], level, drive, invert, direction);

    // bus state machine
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            state   <= io_expander_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            rw      <= 1'b0;
            acked   <= 1'b0;
        end
        else if (i_ce)
        begin
            if (bus_start)
            begin
                state   <= io_expander_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
            end
            else if (bus_stop)
                state <= io_expander_pkg::ST_IDLE;
            else
            begin
                unique case (state)
                    io_expander_pkg::ST_IDLE:
                    begin
                    end
                    io_expander_pkg::ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift   <= shift_in(shift, sda_s);
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (byte_end)
                        begin
                            state <= addr_hit ? io_expander_pkg::ST_ADDR_ACK : io_expander_pkg::ST_IDLE;
                            rw    <= shift[0];
                        end
                    end
                    io_expander_pkg::ST_CMD:
                    begin
                        if (scl_rise)
                        begin
                            shift   <= shift_in(shift, sda_s);
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (byte_end)
                            state <= io_expander_pkg::ST_CMD_ACK;
                    end
                    io_expander_pkg::ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift   <= shift_in(shift, sda_s);
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (byte_end)
                            state <= io_expander_pkg::ST_WDATA_ACK;
                    end
                    io_expander_pkg::ST_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (rw)
                            begin
                                state <= io_expander_pkg::ST_RDATA;
                                shift <= rd_byte;
                            end
                            else
                                state <= io_expander_pkg::ST_CMD;
                        end
                    end
                    io_expander_pkg::ST_CMD_ACK, io_expander_pkg::ST_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state   <= io_expander_pkg::ST_WDATA;
                            bit_cnt <= 4'h0;
                        end
                    end
                    io_expander_pkg::ST_RDATA:
                    begin
                        if (scl_rise)
                            bit_cnt <= bit_cnt + 4'h1;
                        else if (byte_end)
                            state <= io_expander_pkg::ST_MACK;
                        else if (scl_fall)
                            shift <= {shift[6:0], 1'b0};
                    end
                    io_expander_pkg::ST_MACK:
                    begin
                        if (scl_rise)
                            acked <= ~sda_s;
                        else if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (acked)
                            begin
                                state <= io_expander_pkg::ST_RDATA;
                                shift <= rd_byte;
                            end
                            else
                                state <= io_expander_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // data line: low for acknowledges, released bit by bit for reads
    always_comb
    begin
        unique case (state)
            io_expander_pkg::ST_ADDR_ACK,
            io_expander_pkg::ST_CMD_ACK,
            io_expander_pkg::ST_WDATA_ACK: next_sda_oe_n = 1'b0;
            io_expander_pkg::ST_RDATA:     next_sda_oe_n = shift[7];
            default:                       next_sda_oe_n = 1'b1;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            o_sda_oe_n <= 1'b1;
        else if (i_ce)
            o_sda_oe_n <= next_sda_oe_n;
    end

    assign o_sda = 1'b0;

    // command pointer, never readable
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            ptr <= io_expander_pkg::COMMAND_RESET;
        else if (i_ce)
        begin
            if (cmd_done)
                ptr <= shift;
            else if (wr_done || mack_rise)
                ptr[0] <= ~ptr[0];
        end
    end

    // configuration registers, addressed by low three pointer bits
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            drive     <= {2{io_expander_pkg::DRIVE_VALUE_RESET}};
            invert    <= {2{io_expander_pkg::INVERT_MASK_RESET}};
            direction <= {2{io_expander_pkg::DIRECTION_RESET}};
        end
        else if (i_ce && wr_done)
        begin
            unique case (ptr[2:0])
                io_expander_pkg::REG_PIN_LEVEL_LO,
                io_expander_pkg::REG_PIN_LEVEL_HI:
                begin
                    // input levels are read-only, byte dropped
                end
                io_expander_pkg::REG_DRIVE_VALUE_LO: drive.lo     <= shift;
                io_expander_pkg::REG_DRIVE_VALUE_HI: drive.hi     <= shift;
                io_expander_pkg::REG_INVERT_MASK_LO: invert.lo    <= shift;
                io_expander_pkg::REG_INVERT_MASK_HI: invert.hi    <= shift;
                io_expander_pkg::REG_DIRECTION_LO:   direction.lo <= shift;
                io_expander_pkg::REG_DIRECTION_HI:   direction.hi <= shift;
            endcase
        end
    end

    // pins: value from drive bit, enable low only on output pins
    assign o_port_pin  = drive;
    assign o_port_oe_n = direction;

    // last captured levels; a port read re-captures that port
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            snapshot <= 16'h0000;
            primed   <= 1'b0;
            warm     <= 2'h0;
        end
        else if (i_ce)
        begin
            warm <= {warm[0], 1'b1};
            if (!primed)
            begin
                // wait out the synchroniser reset value before capturing
                snapshot <= level;
                primed   <= warm[1];
            end
            else if (mack_rise && (ptr[2:1] == 2'b00))
            begin
                // a change in this cycle goes into the capture; a change in the next cycle differs from it
                if (ptr[0])
                    snapshot.hi <= level.hi;
                else
                    snapshot.lo <= level.lo;
            end
        end
    end

    // pending while any input pin differs from its capture
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            o_int_oe_n <= 1'b1;
        else if (i_ce)
            o_int_oe_n <= ~(primed && (mismatch != 16'h0000));
    end

    assign o_int = 1'b0;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    sequence s_lo_read_cleared;
        (mack_rise && ptr[2:0] == 3'h0 && i_ce) ##1 (i_ce && level == $past(level) && mismatch.hi == 8'h00);
    endsequence

    sequence s_cmd_ack_held;
        (state == io_expander_pkg::ST_CMD_ACK)[*2];
    endsequence

    a_addr_hit_ack: assert property (addr_hit && i_ce |=> state == io_expander_pkg::ST_ADDR_ACK)
        else $error("matching address not acknowledged");
    a_rw_read_dir: assert property (
        (state == io_expander_pkg::ST_ADDR_ACK && rw && scl_fall && i_ce && !bus_start && !bus_stop)
        |=> state == io_expander_pkg::ST_RDATA)
        else $error("read bit did not start a read");
    a_cmd_capture: assert property (cmd_done && i_ce |=> ptr == $past(shift))
        else $error("command byte not captured");
    a_ack_low: assert property (s_cmd_ack_held |-> !o_sda_oe_n)
        else $error("command byte acknowledge not driven");
    a_wr_toggle: assert property (wr_done && i_ce |=>
        ptr[0] != $past(ptr[0]) && ptr[7:1] == $past(ptr[7:1]))
        else $error("write did not toggle pair");
    a_rd_toggle: assert property (mack_rise && i_ce |=> ptr[0] != $past(ptr[0]))
        else $error("read did not toggle pair");
    a_input_ro: assert property ((wr_done && ptr[2:1] == 2'b00) |=>
        $stable(drive) && $stable(invert) && $stable(direction))
        else $error("write to input level changed a register");
    a_reset_values: assert property (disable iff (1'b0) i_reset |=>
        drive == 16'hFFFF && invert == 16'h0000 && direction == 16'hFFFF && o_int_oe_n)
        else $error("wrong values after reset");
    a_int_raise: assert property ((primed && mismatch != 16'h0000 && i_ce) |=> !o_int_oe_n)
        else $error("input change did not raise interrupt");
    a_int_clear: assert property (s_lo_read_cleared |=> o_int_oe_n)
        else $error("port read did not clear interrupt");
endmodule : io_expander_core

// [bench/serial_master_model.sv]
// two-wire bus master model: start, stop and nine-bit transfers
`timescale 1ns/1ns
module serial_master_model (
    input  wire logic i_mclk,
    input  wire logic i_sda_wire,
    output logic      o_scl,
    output logic      o_sda
);
    logic in_frame = 1'b0;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : wait_clk
    // first=1 gives start or restart, first=0 gives stop; clock idles high
    task automatic cond(input logic first);
        if (in_frame)
        begin
            o_scl <= 1'b0;
            wait_clk(3);
        end
        o_sda <= first;
        wait_clk(3);
        o_scl <= 1'b1;
        wait_clk(4);
        o_sda <= ~first;
        wait_clk(4);
        in_frame = first;
    endtask : cond
    // low six cycles, high two: 320 ns a bit; line sampled while clock high
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            o_scl <= 1'b0;
            wait_clk(3);
            o_sda <= d[i];
            wait_clk(3);
            o_scl <= 1'b1;
            wait_clk(1);
            q[i] = i_sda_wire;
            wait_clk(1);
        end
    endtask : xfer
endmodule : serial_master_model

// [bench/io_expander_core_tb.sv]
// self-checking bench for the serial-bus port expander core
`timescale 1ns/1ns
module io_expander_core_tb;
    localparam logic [3:0]  ADDR_BASE = 4'h2;
    localparam logic [15:0] DIR       = 16'hF00F;
    localparam logic [15:0] DRV       = 16'hA53C;
    localparam logic [15:0] INV       = 16'h00FF;
    logic                        i_mclk  = 1'b0;
    logic                        i_reset = 1'b1;
    logic [2:0]                  strap   = 3'h5;
    io_expander_pkg::port_pair_t pin_ext = 16'h5AC3;
    io_expander_pkg::port_pair_t pin_wire;
    io_expander_pkg::port_pair_t port_pin;
    io_expander_pkg::port_pair_t port_oe_n;
    logic                        m_scl;
    logic                        m_sda;
    logic                        sda_oe_n;
    logic                        sda_out;
    logic                        int_oe_n;
    logic                        int_val;
    logic                        ce      = 1'b1;
    wire logic                   sda_wire;
    int                          error_cnt = 0;
    int                          cmp_count = 0;
    int                          cycles    = 0;

    always #20 i_mclk = ~i_mclk;
    // released data line floats high
    assign sda_wire = m_sda & (sda_oe_n | sda_out);
    assign pin_wire = (pin_ext & port_oe_n) | (port_pin & ~port_oe_n);

    io_expander_core #(.ADDR_BASE(ADDR_BASE)) dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_scl(m_scl), .i_sda(sda_wire),
        .o_sda(sda_out), .o_sda_oe_n(sda_oe_n), .i_addr_strap(strap), .i_port_pin(pin_wire),
        .o_port_pin(port_pin), .o_port_oe_n(port_oe_n), .o_int(int_val), .o_int_oe_n(int_oe_n)
    );
    serial_master_model bfm (.i_mclk(i_mclk), .i_sda_wire(sda_wire), .o_scl(m_scl), .o_sda(m_sda));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic settle();
        repeat (6) @(posedge i_mclk);
    endtask : settle
    task automatic wr2(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        logic [8:0] q;
        bfm.cond(1'b1);
        bfm.xfer({ADDR_BASE, strap, 1'b0, 1'b1}, q);
        check(q[0], 1'b0);
        bfm.xfer({cmd, 1'b1}, q);
        bfm.xfer({d0, 1'b1}, q);
        bfm.xfer({d1, 1'b1}, q);
        check(q[0], 1'b0);
        bfm.cond(1'b0);
    endtask : wr2
    task automatic rd2(input logic set_cmd, input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
        logic [8:0] q;
        if (set_cmd)
        begin
            bfm.cond(1'b1);
            bfm.xfer({ADDR_BASE, strap, 1'b0, 1'b1}, q);
            bfm.xfer({cmd, 1'b1}, q);
        end
        bfm.cond(1'b1);
        bfm.xfer({ADDR_BASE, strap, 1'b1, 1'b1}, q);
        check(q[0], 1'b0);
        bfm.xfer(9'h1FE, q);
        check(q[8:1], e0);
        bfm.xfer(9'h1FF, q);
        check(q[8:1], e1);
        bfm.cond(1'b0);
    endtask : rd2
    task automatic rd_levels();
        logic [15:0] e;
        e = ((pin_ext & DIR) | (DRV & ~DIR)) ^ INV;
        rd2(1'b1, 8'h00, e[7:0], e[15:8]);
    endtask : rd_levels
    task automatic t_defaults();
        check(port_oe_n, 16'hFFFF);
        check(port_pin, 16'hFFFF);
        check(int_oe_n, 1'b1);
        check(int_val, 1'b0);
        rd2(1'b1, 8'h02, 8'hFF, 8'hFF);
        rd2(1'b1, 8'h04, 8'h00, 8'h00);
        rd2(1'b1, 8'h06, 8'hFF, 8'hFF);
    endtask : t_defaults
    task automatic t_pairs();
        wr2(8'h03, DRV[15:8], DRV[7:0]);
        wr2(8'hFE, DIR[7:0], DIR[15:8]);
        @(posedge i_mclk);
        check(port_oe_n, DIR);
        check(port_pin, DRV);
        rd2(1'b1, 8'h03, DRV[15:8], DRV[7:0]);
        rd2(1'b0, 8'h00, DRV[15:8], DRV[7:0]);
    endtask : t_pairs
    task automatic t_levels();
        wr2(8'h04, INV[7:0], INV[15:8]);
        rd_levels();
        wr2(8'h00, 8'h12, 8'h34);
        rd_levels();
    endtask : t_levels
    task automatic t_interrupt();
        settle();
        check(int_oe_n, 1'b1);
        pin_ext.lo[0] <= ~pin_ext.lo[0];
        settle();
        check(int_oe_n, 1'b0);
        pin_ext.lo[0] <= ~pin_ext.lo[0];
        settle();
        check(int_oe_n, 1'b1);
        pin_ext.lo[7] <= ~pin_ext.lo[7];
        settle();
        check(int_oe_n, 1'b1);
        pin_ext.lo[1] <= ~pin_ext.lo[1];
        settle();
        check(int_oe_n, 1'b0);
        rd_levels();
        check(int_oe_n, 1'b1);
        // clock enable low freezes sampling and the interrupt
        ce <= 1'b0;
        pin_ext.lo[2] <= ~pin_ext.lo[2];
        settle();
        check(int_oe_n, 1'b1);
        ce <= 1'b1;
        settle();
        check(int_oe_n, 1'b0);
        pin_ext.lo[2] <= ~pin_ext.lo[2];
        settle();
        check(int_oe_n, 1'b1);
    endtask : t_interrupt
    task automatic t_strap();
        logic [8:0] q;
        bfm.cond(1'b1);
        bfm.xfer({ADDR_BASE, ~strap, 1'b0, 1'b1}, q);
        bfm.cond(1'b0);
        check(q[0], 1'b1);
        strap <= 3'h2;
        settle();
        rd2(1'b1, 8'h02, DRV[7:0], DRV[15:8]);
    endtask : t_strap
    task automatic t_reset_mid();
        i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        check(port_oe_n, 16'hFFFF);
        check(port_pin, 16'hFFFF);
        settle();
        rd2(1'b1, 8'h04, 8'h00, 8'h00);
    endtask : t_reset_mid

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        settle();
        t_defaults();
        t_pairs();
        t_levels();
        t_interrupt();
        t_strap();
        t_reset_mid();
        report_and_stop();
    end
endmodule : io_expander_core_tb
